// *** rtl/ccid_pkg.sv ***
// Package for the cache identification register bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package ccid_pkg;
  // Register byte offsets
  localparam logic [11:0] CCID_SEL_OFF = 12'h000;
  localparam logic [11:0] CCID_TYPE_OFF = 12'h004;
  localparam logic [11:0] CCID_SIZE_OFF = 12'h008;
  // Selection field positions
  localparam int CCID_SEL_IND_BIT = 0;
  localparam int CCID_SEL_LVL_LO = 1;
  localparam int CCID_SEL_LVL_HI = 3;
  // Cache type field positions
  localparam int CCID_FMT_LO = 29;
  localparam int CCID_CWG_LO = 24;
  localparam int CCID_ERG_LO = 20;
  localparam int CCID_DMIN_LO = 16;
  localparam int CCID_RAO_LO = 14;
  localparam int CCID_IMIN_LO = 0;
  // Format codes
  localparam logic [2:0] CCID_FMT_NONE = 3'h0;
  localparam logic [2:0] CCID_FMT_V7 = 3'h4;
  localparam logic [3:0] CCID_GRAN_MAX = 4'h9;
  localparam logic [1:0] CCID_RAO_VAL = 2'h3;
  // Value after reset of the stored selection bits (architecturally unknown)
  localparam logic [3:0] CCID_SEL_RST = 4'h0;
  localparam int CCID_NUM_CACHES = 14;
  // Access states, Gray coded
  typedef enum logic [1:0] {
    CCID_IDLE = 2'b00,
    CCID_SETUP = 2'b01,
    CCID_ACCESS = 2'b11
  } ccid_state_e;
endpackage

// *** rtl/ccid_size_rom.sv ***
// Per-cache size identification words, selected by level and type.
// Assumes the selection comes from the selection register in ccid_regs.
`timescale 1ns/1ps
`default_nettype none
module ccid_size_rom
  import ccid_pkg::*;
#(
  parameter logic [13:0] PRESENT = 14'h0003,
  parameter logic [31:0] SIZE_WORD = 32'h7003E019
)
(
  // Selection
  input wire logic [3:0] sel,
  // Result
  output logic [31:0] size_word,
  output logic present
);
  logic [31:0] words [CCID_NUM_CACHES];
  genvar g;
  // One size word per possible cache; absent ones read zero
  generate
    for (g = 0; g < CCID_NUM_CACHES; g++)
    begin : g_cache
      assign words[g] = PRESENT[g] ? SIZE_WORD : 32'h00000000;
    end
  endgenerate
  always_comb
  begin
    present = 1'b0;
    size_word = 32'h00000000;
    if (sel < 4'(CCID_NUM_CACHES))
    begin
      present = PRESENT[sel];
      size_word = words[sel];
    end
  end
endmodule // ccid_size_rom
`default_nettype wire

// *** rtl/ccid_regs.sv ***
// Cache identification register bank on APB.
// Assumes pprot[0] marks privileged access; the CPU clocks pclk.
`timescale 1ns/1ps
`default_nettype none
module ccid_regs
  import ccid_pkg::*;
#(
  parameter logic [2:0] FORMAT = CCID_FMT_V7,
  parameter logic [3:0] WB_GRANULE = 4'h0,
  parameter logic [3:0] RES_GRANULE = 4'h0,
  parameter logic [3:0] DLINE_LOG2 = 4'h3,
  parameter logic [3:0] ILINE_LOG2 = 4'h3,
  parameter logic [13:0] CACHE_PRESENT = 14'h0003
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Current selection, for the cache side
  output logic [3:0] cache_size_select_out
);
  logic [3:0] cache_size_select;
  logic [31:0] cache_type_info;
  logic [31:0] size_word;
  logic size_present;
  logic priv;
  logic hit_sel;
  logic hit_type;
  logic hit_size;
  logic mapped;
  logic access;
  ccid_state_e state;
  ccid_state_e next_state;
  logic [31:0] next_rdata;
  logic next_err;

  assign priv = pprot[0];
  assign hit_sel = (paddr == CCID_SEL_OFF);
  assign hit_type = (paddr == CCID_TYPE_OFF);
  assign hit_size = (paddr == CCID_SIZE_OFF);
  assign mapped = hit_sel | hit_type | hit_size;
  // An enable without a preceding setup cycle is not a transfer
  assign access = psel & penable & (state == CCID_SETUP);
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign cache_size_select_out = cache_size_select;

  // Fixed type word; a reserved granule is clamped to the unknown code
  always_comb
  begin
    cache_type_info = 32'h00000000;
    if (FORMAT != CCID_FMT_NONE)
    begin
      cache_type_info[CCID_FMT_LO +: 3] = FORMAT;
      cache_type_info[CCID_CWG_LO +: 4] =
        (WB_GRANULE > CCID_GRAN_MAX) ? 4'h0 : WB_GRANULE;
      cache_type_info[CCID_ERG_LO +: 4] =
        (RES_GRANULE > CCID_GRAN_MAX) ? 4'h0 : RES_GRANULE;
      cache_type_info[CCID_DMIN_LO +: 4] = DLINE_LOG2;
      cache_type_info[CCID_RAO_LO +: 2] = CCID_RAO_VAL;
      cache_type_info[CCID_IMIN_LO +: 4] = ILINE_LOG2;
    end
  end

  ccid_size_rom #(
    .PRESENT(CACHE_PRESENT),
    .SIZE_WORD(32'h7003E019)
  ) u_rom (
    .sel(cache_size_select),
    .size_word(size_word),
    .present(size_present)
  );

  // Bus phase of the previous cycle
  always_comb
  begin
    next_state = CCID_IDLE;
    case ({psel, penable})
      2'b10: next_state = CCID_SETUP;
      2'b11: next_state = CCID_ACCESS;
      default: next_state = CCID_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= CCID_IDLE;
    else
      state <= next_state;
  end

  // Selection register; only the low nibble is stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cache_size_select <= CCID_SEL_RST;
    else if (access && pwrite && priv && hit_sel && pstrb[0])
      cache_size_select <= pwdata[CCID_SEL_LVL_HI:CCID_SEL_IND_BIT];
  end

  // Read data and error
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (!priv || !mapped)
      next_err = 1'b1;
    else if (pwrite)
      next_err = !hit_sel;
    else if (hit_sel)
      next_rdata = {28'h0000000, cache_size_select};
    else if (hit_type)
      next_rdata = cache_type_info;
    else
      next_rdata = size_present ? size_word : 32'h00000000;
  end

  // Read data is captured at the end of setup, so it comes from a flop
  // and still needs no wait state; it reads zero outside the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_rdata;
    else
      prdata <= 32'h00000000;
  end
  assign pslverr = access & next_err;
endmodule // ccid_regs
`default_nettype wire

// *** verif/ccid_regs_properties.sv ***
// Checker for the cache identification bank, bound to ccid_regs.
// Assumes default parameters and zero-wait APB.
`timescale 1ns/1ps
`default_nettype none
module ccid_regs_properties
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Selection
  input wire logic [3:0] cache_size_select_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pprot[0];
  wire logic rd = acc && !pwrite;
  wire logic wsel = acc && pwrite && paddr == 12'h000 && pstrb[0];
  a_type_word: assert property (
    rd && paddr == 12'h004 |-> prdata == 32'h8003C003)
    else $error("type word wrong");
  a_sel_read: assert property (
    rd && paddr == 12'h000 |-> prdata == {28'h0, cache_size_select_out})
    else $error("selection read wrong");
  a_sel_write: assert property (
    wsel |=> {28'h0, cache_size_select_out} == ($past(pwdata) & 32'hF))
    else $error("selection write lost");
  a_size_word: assert property (
    rd && paddr == 12'h008 && cache_size_select_out < 4'h2
    |-> prdata == 32'h7003E019) else $error("size word wrong");
  a_absent_zero: assert property (
    rd && paddr == 12'h008 && cache_size_select_out > 4'h1
    |-> prdata == 32'h0) else $error("absent cache not zero");
  a_unpriv_err: assert property (
    psel && penable && !pprot[0] |-> pslverr)
    else $error("unprivileged access accepted");
  a_no_stray: assert property (
    psel && penable && !wsel |=> $stable(cache_size_select_out))
    else $error("selection changed without write");
  a_type_ro: assert property (
    psel && penable && pwrite && paddr == 12'h004 |-> pslverr)
    else $error("type write accepted");
endmodule // ccid_regs_properties
bind ccid_regs ccid_regs_properties ccid_regs_properties_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cache_size_select_out(cache_size_select_out));
`default_nettype wire

// *** verif/ccid_regs_tb.sv ***
// Self-checking bench for the cache identification register bank.
// Assumes default parameters: level 1 data and instruction caches only.
`timescale 1ns/1ps
`default_nettype none
module ccid_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb, sel_out;
  logic [2:0] pprot;
  int num_errors = 0;
  int num_checks = 0;
  ccid_regs ccid_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cache_size_select_out(sel_out));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic op(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [2:0] pr, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pprot, pstrb} <=
      {2'b10, w, a, d, pr, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    // A slave that never answers counts as a mismatch
    chk("pready", 32'h00000001, {31'h0, pready});
    rdv = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [2:0] pr, input logic [3:0] s, input logic ee);
    op(1'b1, a, d, pr, s);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  // Data of a refused read is not defined, so only the error is compared
  task automatic rd(input logic [11:0] a, input logic [2:0] pr,
    input logic [31:0] ed, input logic ee);
    op(1'b0, a, 32'h0, pr, 4'h0);
    if (!ee)
      chk("prdata", ed, rdv);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, pprot} = 55'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 3'h1, 32'h0, 1'b0);
    for (int i = 0; i < 14; i++)
    begin
      wr(12'h000, {28'hFFFFFFF, 4'(i)}, 3'h1, 4'hF, 1'b0);
      rd(12'h000, 3'h1, 32'(i), 1'b0);
      chk("sel_out", 32'(i), {28'h0, sel_out});
      rd(12'h008, 3'h1, (i < 2) ? 32'h7003E019 : 32'h0, 1'b0);
    end
    $display("selection test done");
    rd(12'h004, 3'h1, 32'h8003C003, 1'b0);
    wr(12'h004, 32'h0, 3'h1, 4'hF, 1'b1);
    rd(12'h004, 3'h1, 32'h8003C003, 1'b0);
    $display("type test done");
    wr(12'h000, 32'h2, 3'h0, 4'hF, 1'b1);
    rd(12'h000, 3'h0, 32'h0, 1'b1);
    wr(12'h000, 32'h4, 3'h1, 4'hE, 1'b0);
    rd(12'h00C, 3'h1, 32'h0, 1'b1);
    rd(12'h000, 3'h1, 32'hD, 1'b0);
    $display("refusal test done");
    wrap_up();
  end
endmodule // ccid_regs_tb
`default_nettype wire
